// [core/lcd_cmd_device.sv]
// Display controller end: decodes command bytes and stores display data.
// Assumes a host end on lcd_bus_if driving one-cycle strobes on clk_sys.
//
// Overview of operation
// R1 - Flagged opcode sets or clears pixel negation.
// R2 - Flagged opcode forces all dots lit.
// R3 - Bias bit picks one ninth or seventh.
// R4 - Read-modify-write: reads hold, writes advance column.
// R5 - Nibble C opcode bit 3 flips row scan.
// R6 - Power opcode switches booster, regulator, follower.
// R7 - Ratio opcode loads three-bit resistor ratio.
// R8 - Contrast opener, then six-bit step operand.
// R9 - Sleep opener with mode bit, zero operand.
// R10 - Display off plus all dots means power save.
// R11 - Booster opener, then two-bit pump factor.
// R12 - Host never sends reserved test codes.
// R13 - Flagged opcode turns panel on or off.
// R14 - Data-select writes go to display memory.
// R15 - Soft reset restores defaults; nop does nothing.
// R16 - Byte after an opener is its operand.
`include "lcd_cmd_map.svh"
`timescale 1ns/10ps
`default_nettype none

module lcd_cmd_device (
   input wire logic clk_sys,
   input wire logic rst_n,
   lcd_bus_if.device bus,
   output logic displayOn,
   output logic negatePixels,
   output logic lightEveryDot,
   output logic biasPick,
   output logic segFlip,
   output logic rowScanFlip,
   output logic booster_on,
   output logic regulator_on,
   output logic follower_on,
   output logic [2:0] resistorRatio,
   output logic [5:0] contrastStep,
   output logic [1:0] pumpFactor,
   output logic sleepActive,
   output logic powerSaveActive,
   output logic rmwActive,
   output logic [5:0] startLine,
   output logic [3:0] pageAddr,
   output logic [7:0] columnAddr
);
   localparam int AW = `LCD_PAGE_BITS + `LCD_COL_BITS;

   lcd_cmd_pkg::lcd_opnd_t pending;
   logic pendingMode;
   logic cmdWr;
   logic dataWr;
   logic dataRd;
   logic isOp;
   logic isOperand;
   logic softReset;
   logic [7:0] cmd;
   logic inRange;
   logic [AW-1:0] ramAddr;
   logic [7:0] ramQ;

   // Strobe classes; a command byte is an operand while one is pending.
   assign cmd = bus.busWrData;
   assign cmdWr = bus.busWrite && !bus.cmdDataSelect;
   assign dataWr = bus.busWrite && bus.cmdDataSelect;
   assign dataRd = bus.busRead && bus.cmdDataSelect;
   assign isOperand = cmdWr && (pending != lcd_cmd_pkg::OPND_NONE); // R16
   assign isOp = cmdWr && (pending == lcd_cmd_pkg::OPND_NONE); // R16
   assign softReset = isOp && (cmd == `LCD_OP_SOFT_RESET); // R15

   // Tracks which operand, if any, the next command byte supplies.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pending <= lcd_cmd_pkg::OPND_NONE;
         pendingMode <= 1'b0;
      end else if (isOperand) begin
         pending <= lcd_cmd_pkg::OPND_NONE; // R16
      end else if (isOp) begin
         if (cmd == `LCD_OP_CONTRAST) begin
            pending <= lcd_cmd_pkg::OPND_CONTRAST; // R8
         end else if (cmd[7:1] == `LCD_OP_SLEEP) begin
            pending <= lcd_cmd_pkg::OPND_SLEEP; // R9
            pendingMode <= cmd[`LCD_BIT_FLAG];
         end else if (cmd == `LCD_OP_BOOSTER) begin
            pending <= lcd_cmd_pkg::OPND_BOOSTER; // R11
         end
      end
   end

   // Display flags set by single-byte flagged opcodes and by bit 3 of the nibble C opcode.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         displayOn <= 1'b0;
         negatePixels <= 1'b0;
         lightEveryDot <= 1'b0;
         biasPick <= 1'b0;
         segFlip <= 1'b0;
         rowScanFlip <= 1'b0;
      end else if (softReset) begin
         displayOn <= 1'b0; // R15
         negatePixels <= 1'b0;
         lightEveryDot <= 1'b0;
         biasPick <= 1'b0;
         segFlip <= 1'b0;
         rowScanFlip <= 1'b0;
      end else if (isOp) begin
         if (cmd[7:1] == `LCD_OP_DISPLAY) begin
            displayOn <= cmd[`LCD_BIT_FLAG]; // R13
         end
         if (cmd[7:1] == `LCD_OP_NEGATE) begin
            negatePixels <= cmd[`LCD_BIT_FLAG]; // R1
         end
         if (cmd[7:1] == `LCD_OP_ALL_DOTS) begin
            lightEveryDot <= cmd[`LCD_BIT_FLAG]; // R2
         end
         if (cmd[7:1] == `LCD_OP_BIAS) begin
            biasPick <= cmd[`LCD_BIT_FLAG]; // R3
         end
         if (cmd[7:1] == `LCD_OP_SEG_DIR) begin
            segFlip <= cmd[`LCD_BIT_FLAG];
         end
         if (cmd[7:4] == `LCD_OP_COM_DIR) begin
            rowScanFlip <= cmd[`LCD_BIT_ROW_FLIP]; // R5
         end
      end
   end

   // Power circuit switches and the regulation resistor ratio.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         booster_on <= 1'b0;
         regulator_on <= 1'b0;
         follower_on <= 1'b0;
         resistorRatio <= `LCD_RST_RATIO;
      end else if (softReset) begin
         booster_on <= 1'b0; // R15
         regulator_on <= 1'b0;
         follower_on <= 1'b0;
         resistorRatio <= `LCD_RST_RATIO;
      end else if (isOp) begin
         if (cmd[7:3] == `LCD_OP_POWER) begin
            booster_on <= cmd[`LCD_BIT_BOOSTER]; // R6
            regulator_on <= cmd[`LCD_BIT_REGULATOR];
            follower_on <= cmd[`LCD_BIT_FOLLOWER];
         end
         if (cmd[7:3] == `LCD_OP_RATIO) begin
            resistorRatio <= cmd[2:0]; // R7
         end
      end
   end

   // Two-byte settings, applied when their operand arrives.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         contrastStep <= `LCD_RST_CONTRAST;
         pumpFactor <= `LCD_RST_PUMP;
         sleepActive <= 1'b0;
      end else if (softReset) begin
         contrastStep <= `LCD_RST_CONTRAST; // R15
         pumpFactor <= `LCD_RST_PUMP;
         sleepActive <= 1'b0;
      end else if (isOperand) begin
         case (pending)
            lcd_cmd_pkg::OPND_CONTRAST: begin
               contrastStep <= cmd[5:0]; // R8
            end
            lcd_cmd_pkg::OPND_SLEEP: begin
               sleepActive <= !pendingMode; // R9
            end
            lcd_cmd_pkg::OPND_BOOSTER: begin
               pumpFactor <= cmd[1:0]; // R11
            end
            default: begin
            end
         endcase
      end
   end

   // Compound power save follows display off with all dots lit.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         powerSaveActive <= 1'b0;
      end else begin
         powerSaveActive <= !displayOn && lightEveryDot; // R10
      end
   end

   // Read-modify-write mode entry and exit.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rmwActive <= 1'b0;
      end else if (softReset) begin
         rmwActive <= 1'b0; // R15
      end else if (isOp && cmd == `LCD_OP_RMW_ENTER) begin
         rmwActive <= 1'b1; // R4
      end else if (isOp && cmd == `LCD_OP_RMW_EXIT) begin
         rmwActive <= 1'b0; // R4
      end
   end

   // Start line, page and column addresses; data writes, and reads outside read-modify-write, move the column.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         startLine <= `LCD_RST_START;
         pageAddr <= 4'h0;
         columnAddr <= 8'h00;
      end else if (softReset) begin
         startLine <= `LCD_RST_START; // R15
         pageAddr <= 4'h0;
         columnAddr <= 8'h00;
      end else if (isOp) begin
         if (cmd[7:6] == `LCD_OP_START) begin
            startLine <= cmd[5:0];
         end
         if (cmd[7:4] == `LCD_OP_PAGE) begin
            pageAddr <= cmd[3:0];
         end
         if (cmd[7:4] == `LCD_OP_COL_HI) begin
            columnAddr <= {cmd[3:0], columnAddr[3:0]};
         end
         if (cmd[7:4] == `LCD_OP_COL_LO) begin
            columnAddr <= {columnAddr[7:4], cmd[3:0]};
         end
      end else if (dataWr) begin
         columnAddr <= columnAddr + 8'h01; // R4
      end else if (dataRd && !rmwActive) begin
         columnAddr <= columnAddr + 8'h01; // R4
      end
   end

   // Display memory at the current page and column.
   assign inRange = ({4'h0, pageAddr} < `LCD_PAGES) &&
                    (columnAddr < `LCD_COLS);
   assign ramAddr = {pageAddr[`LCD_PAGE_BITS-1:0],
                     columnAddr[`LCD_COL_BITS-1:0]};

   lcd_frame_ram #(
      .AW(AW)
   ) u_ram (
      .clk_sys(clk_sys),
      .wrEn(dataWr && inRange), // R14
      .addr(ramAddr),
      .wrData(cmd),
      .rdData(ramQ)
   );

   // Read answer one cycle after the strobe: memory byte or status.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.busRdData <= 8'h00;
         bus.busRdValid <= 1'b0;
      end else begin
         bus.busRdValid <= bus.busRead;
         if (dataRd) begin
            bus.busRdData <= inRange ? ramQ : 8'h00;
         end else if (bus.busRead) begin
            bus.busRdData <= {1'b0, segFlip, !displayOn, sleepActive, 4'h0};
         end
      end
   end
endmodule

`default_nettype wire

// [core/lcd_cmd_map.svh]
// Opcodes, field positions, reset values and timing counts of the
// display command decoder.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef LCD_CMD_MAP_SVH
`define LCD_CMD_MAP_SVH

// Seven-bit opcode prefixes whose bit 0 carries a flag.
`define LCD_OP_DISPLAY 7'h57
`define LCD_OP_NEGATE 7'h53
`define LCD_OP_ALL_DOTS 7'h52
`define LCD_OP_BIAS 7'h51
`define LCD_OP_SEG_DIR 7'h50
`define LCD_OP_SLEEP 7'h56
// Whole-byte opcodes.
`define LCD_OP_RMW_ENTER 8'hE0
`define LCD_OP_RMW_EXIT 8'hEE
`define LCD_OP_SOFT_RESET 8'hE2
`define LCD_OP_NOP 8'hE3
`define LCD_OP_CONTRAST 8'h81
`define LCD_OP_BOOSTER 8'hF8
// Nibble and partial prefixes.
`define LCD_OP_COM_DIR 4'hC
`define LCD_OP_PAGE 4'hB
`define LCD_OP_COL_HI 4'h1
`define LCD_OP_COL_LO 4'h0
`define LCD_OP_TEST 4'hF
`define LCD_OP_POWER 5'h05
`define LCD_OP_RATIO 5'h04
`define LCD_OP_START 2'h1
// Field positions.
`define LCD_BIT_FLAG 0
`define LCD_BIT_ROW_FLIP 3
`define LCD_BIT_BOOSTER 2
`define LCD_BIT_REGULATOR 1
`define LCD_BIT_FOLLOWER 0
// Reset values of the command-set registers.
`define LCD_RST_CONTRAST 6'h00
`define LCD_RST_RATIO 3'h0
`define LCD_RST_PUMP 2'h0
`define LCD_RST_START 6'h00
// Display memory geometry.
`define LCD_PAGE_BITS 3
`define LCD_COL_BITS 7
`define LCD_PAGES 8'h08
`define LCD_COLS 8'h80
// Host strobe spacing: gap cycles the sequencer holds after each bus strobe.
`define LCD_HOST_GAP 1

`endif

// [core/lcd_cmd_pkg.sv]
// Types shared by both ends of the display command link.
// Assumes nothing beyond a SystemVerilog compiler.
package lcd_cmd_pkg;

   // Operand that the next command byte will be taken as.
   typedef enum logic [1:0] {
      OPND_NONE,
      OPND_CONTRAST,
      OPND_SLEEP,
      OPND_BOOSTER
   } lcd_opnd_t;

   // Host strobe sequencer states.
   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_STROBE,
      HOST_GAP
   } lcd_host_state_t;

endpackage

// [core/lcd_bus_if.sv]
// Interface carrying the host port strobes between the two ends.
// Assumes both ends run on the same clk_sys.
`timescale 1ns/10ps
`default_nettype none

interface lcd_bus_if;
   logic busWrite;
   logic busRead;
   logic cmdDataSelect;
   logic [7:0] busWrData;
   logic [7:0] busRdData;
   logic busRdValid;

   modport device (
      input busWrite,
      input busRead,
      input cmdDataSelect,
      input busWrData,
      output busRdData,
      output busRdValid
   );

   modport host (
      output busWrite,
      output busRead,
      output cmdDataSelect,
      output busWrData,
      input busRdData,
      input busRdValid
   );
endinterface

`default_nettype wire

// [core/lcd_frame_ram.sv]
// Display memory: one synchronous write port, one combinational read.
// Assumes the caller keeps addresses in range.
`timescale 1ns/10ps
`default_nettype none

module lcd_frame_ram #(
   parameter int AW = 10
) (
   input wire logic clk_sys,
   input wire logic wrEn,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData
);
   logic [7:0] mem [0:(1<<AW)-1];

   // Stores a display byte; memory holds no reset, as on the panel.
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[addr] <= wrData;
      end
   end

   // Reads the byte at the current address.
   assign rdData = mem[addr];
endmodule

`default_nettype wire

// [core/lcd_cmd_host.sv]
// Host end: turns user requests into one-cycle strobes on the link.
// Assumes a device end on lcd_bus_if answering reads one cycle later.
`include "lcd_cmd_map.svh"
`timescale 1ns/10ps
`default_nettype none

module lcd_cmd_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   lcd_bus_if.host bus,
   input wire logic reqValid,
   input wire logic reqRead,
   input wire logic reqIsData,
   input wire logic [7:0] reqByte,
   output logic reqReady,
   output logic reqRejected,
   output logic [7:0] readData,
   output logic readDone
);
   lcd_cmd_pkg::lcd_host_state_t state;
   logic expectOperand;
   logic take;
   logic isTest;
   logic isOpener;

   assign take = reqValid && reqReady;
   assign isOpener = (reqByte == `LCD_OP_CONTRAST) ||
                     (reqByte[7:1] == `LCD_OP_SLEEP) ||
                     (reqByte == `LCD_OP_BOOSTER);
   // Reserved test codes are refused unless they are an operand.
   assign isTest = !reqRead && !reqIsData && !expectOperand &&
                   (reqByte[7:4] == `LCD_OP_TEST) &&
                   (reqByte != `LCD_OP_BOOSTER); // R12

   // Strobe sequencer: one strobe cycle, then a gap cycle.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= lcd_cmd_pkg::HOST_IDLE;
         reqReady <= 1'b0;
      end else begin
         case (state)
            lcd_cmd_pkg::HOST_IDLE: begin
               reqReady <= 1'b1;
               if (take && !isTest) begin
                  state <= lcd_cmd_pkg::HOST_STROBE;
                  reqReady <= 1'b0;
               end
            end
            lcd_cmd_pkg::HOST_STROBE: begin
               state <= lcd_cmd_pkg::HOST_GAP;
            end
            lcd_cmd_pkg::HOST_GAP: begin
               state <= lcd_cmd_pkg::HOST_IDLE;
               reqReady <= 1'b1;
            end
            default: begin
               state <= lcd_cmd_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // Drives the link for the one cycle that follows acceptance.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.busWrite <= 1'b0;
         bus.busRead <= 1'b0;
         bus.cmdDataSelect <= 1'b0;
         bus.busWrData <= 8'h00;
      end else begin
         bus.busWrite <= take && !isTest && !reqRead;
         bus.busRead <= take && reqRead;
         if (take && !isTest) begin
            bus.cmdDataSelect <= reqIsData;
            bus.busWrData <= reqByte;
         end
      end
   end

   // Remembers that the last command sent was a two-byte opener.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         expectOperand <= 1'b0;
      end else if (take && !reqRead && !reqIsData && !isTest) begin
         expectOperand <= !expectOperand && isOpener; // R8 R9 R11
      end
   end

   // Refusal pulse and read answer capture.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reqRejected <= 1'b0;
         readData <= 8'h00;
         readDone <= 1'b0;
      end else begin
         reqRejected <= take && isTest; // R12
         readDone <= bus.busRdValid;
         if (bus.busRdValid) begin
            readData <= bus.busRdData;
         end
      end
   end
endmodule

`default_nettype wire

// [verification/lcd_cmd_props.sv]
// Concurrent checks on the link between the host and device ends.
// Assumes plain connections to the link signals and device outputs.
`timescale 1ns/10ps
`default_nettype none

module lcd_cmd_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic cmdDataSelect,
   input wire logic [7:0] busWrData,
   input wire logic displayOn,
   input wire logic negatePixels,
   input wire logic lightEveryDot,
   input wire logic rowScanFlip,
   input wire logic booster_on,
   input wire logic regulator_on,
   input wire logic follower_on,
   input wire logic [5:0] contrastStep,
   input wire logic [1:0] pumpFactor,
   input wire logic sleepActive,
   input wire logic powerSaveActive,
   input wire logic rmwActive,
   input wire logic [7:0] columnAddr
);
   logic cmdW;
   logic dec;
   logic psCause;
   logic [7:0] opener;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Command strobes, and those decoded as instructions.
   assign cmdW = busWrite && !cmdDataSelect;
   assign dec = cmdW && opener == 8'h00;
   assign psCause = !displayOn && lightEveryDot;

   // Remembers a two-byte opener until its operand byte passes.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opener <= 8'h00;
      end else if (cmdW) begin
         opener <= (opener == 8'h00 && (busWrData == 8'h81 ||
            busWrData == 8'hF8 || busWrData[7:1] == 7'h56)) ?
            busWrData : 8'h00;
      end
   end

   chk_negate_flag: assert property (dec && busWrData[7:1] == 7'h53 |=>
      negatePixels == $past(busWrData[0])) else $error("negate wrong");
   chk_all_dots: assert property (dec && busWrData[7:1] == 7'h52 |=>
      lightEveryDot == $past(busWrData[0])) else $error("dots wrong");
   chk_display_flag: assert property (dec && busWrData[7:1] == 7'h57 |=>
      displayOn == $past(busWrData[0])) else $error("display wrong");
   chk_row_scan: assert property (dec && busWrData[7:4] == 4'hC |->
      ##1 rowScanFlip == $past(busWrData[3])) else $error("scan wrong");
   chk_power_bits: assert property (dec && busWrData[7:3] == 5'h05 |=>
      {booster_on, regulator_on, follower_on} == $past(busWrData[2:0]))
      else $error("power bits wrong");
   chk_contrast_operand: assert property (cmdW && opener == 8'h81 |=>
      contrastStep == $past(busWrData[5:0])) else $error("contrast wrong");
   chk_pump_operand: assert property (cmdW && opener == 8'hF8 |=>
      pumpFactor == $past(busWrData[1:0])) else $error("pump wrong");
   chk_sleep_mode: assert property (cmdW && opener[7:1] == 7'h56 |=>
      sleepActive != $past(opener[0])) else $error("sleep wrong");
   chk_power_save: assert property (1'b1 |=>
      powerSaveActive == $past(psCause)) else $error("power save wrong");
   chk_rmw_read_hold: assert property (rmwActive && busRead &&
      cmdDataSelect |=> $stable(columnAddr)) else $error("column moved");
   chk_soft_defaults: assert property (dec && busWrData == 8'hE2 |=>
      contrastStep == 6'h00 && !rmwActive) else $error("reset wrong");

   // Main scenarios that the bench is expected to reach.
   cov_soft_reset: cover property (dec && busWrData == 8'hE2);
   cov_pump_set: cover property (cmdW && opener == 8'hF8);
   cov_rmw_read: cover property (rmwActive && busRead);
endmodule

`default_nettype wire

// [verification/tb_lcd_command_decoder.sv]
// Bench joining the host and device ends through the link interface.
// Assumes the core files and the link interface are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_lcd_command_decoder;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reqValid = 1'b0;
   logic reqRead = 1'b0;
   logic reqIsData = 1'b0;
   logic [7:0] reqByte = 8'h00;
   logic [7:0] readData, columnAddr;
   logic reqReady, reqRejected, readDone, displayOn, negatePixels;
   logic lightEveryDot, biasPick, segFlip, rowScanFlip, booster_on;
   logic regulator_on, follower_on, sleepActive, powerSaveActive, rmwActive;
   logic [2:0] resistorRatio;
   logic [5:0] contrastStep, startLine;
   logic [1:0] pumpFactor;
   logic [3:0] pageAddr;
   logic [3:0] flags;
   logic [7:0] ops [4] = '{8'hAE, 8'hA6, 8'hA4, 8'hA2};
   int nErrors = 0;
   int checked = 0;
   int cycles = 0;

   lcd_bus_if u_lcd_bus_if ();

   lcd_cmd_device u_lcd_cmd_device (.clk_sys, .rst_n, .bus(u_lcd_bus_if),
      .displayOn, .negatePixels, .lightEveryDot, .biasPick, .segFlip,
      .rowScanFlip, .booster_on, .regulator_on, .follower_on,
      .resistorRatio, .contrastStep, .pumpFactor, .sleepActive,
      .powerSaveActive, .rmwActive, .startLine, .pageAddr, .columnAddr);

   lcd_cmd_host u_lcd_cmd_host (.clk_sys, .rst_n, .bus(u_lcd_bus_if),
      .reqValid, .reqRead, .reqIsData, .reqByte, .reqReady, .reqRejected,
      .readData, .readDone);

   lcd_cmd_props u_lcd_cmd_props (.clk_sys, .rst_n,
      .busWrite(u_lcd_bus_if.busWrite), .busRead(u_lcd_bus_if.busRead),
      .cmdDataSelect(u_lcd_bus_if.cmdDataSelect),
      .busWrData(u_lcd_bus_if.busWrData), .displayOn, .negatePixels,
      .lightEveryDot, .rowScanFlip, .booster_on, .regulator_on,
      .follower_on, .contrastStep, .pumpFactor, .sleepActive,
      .powerSaveActive, .rmwActive, .columnAddr);

   // Free-running system clock.
   always #5 clk_sys = ~clk_sys;

   // Cuts a hung run short and counts it as a mismatch.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         nErrors++;
         close_out();
      end
   end

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // Presents one request and returns at the falling edge after its take.
   task automatic put(input logic rd, input logic dat, input logic [7:0] b);
      int n;
      n = 0;
      reqValid = 1'b1;
      reqRead = rd;
      reqIsData = dat;
      reqByte = b;
      @(posedge clk_sys);
      while (!reqReady && n < 20) begin
         n++;
         @(posedge clk_sys);
      end
      chk(8'(n < 20), 8'h01);
      @(negedge clk_sys);
      reqValid = 1'b0;
   endtask

   // Write waits until the device outputs and power save have settled.
   task automatic wr(input logic dat, input logic [7:0] b);
      put(1'b0, dat, b);
      repeat (2) @(negedge clk_sys);
   endtask

   // Read checks the answer in the one cycle that it stands.
   task automatic rd(input logic dat, input logic [7:0] exp);
      put(1'b1, dat, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk(8'(readDone), 8'h01);
      chk(readData, exp);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence of tests.
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      chk(8'(contrastStep), 8'h00);
      chk(8'(pumpFactor), 8'h00);
      for (int f = 1; f >= 0; f--) begin
         for (int i = 0; i < 4; i++) begin
            wr(1'b0, ops[i] | 8'(f));
            flags = {displayOn, negatePixels, lightEveryDot, biasPick};
            chk(8'(flags[3 - i]), 8'(f));
         end
      end
      wr(1'b0, 8'hA5);
      chk(8'(powerSaveActive), 8'h01);
      wr(1'b0, 8'hA4);
      chk(8'(powerSaveActive), 8'h00);
      wr(1'b0, 8'hC8);
      chk(8'(rowScanFlip), 8'h01);
      wr(1'b0, 8'hC7);
      chk(8'(rowScanFlip), 8'h00);
      for (int v = 0; v < 8; v++) begin
         wr(1'b0, 8'h28 | 8'(v));
         chk(8'({booster_on, regulator_on, follower_on}), 8'(v));
         wr(1'b0, 8'h20 | 8'(v));
         chk(8'(resistorRatio), 8'(v));
      end
      $display("test settings done");
      wr(1'b0, 8'h81);
      wr(1'b0, 8'hA7);
      chk(8'(contrastStep), 8'h27);
      chk(8'(negatePixels), 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(1'b0, 8'hF8);
         wr(1'b0, 8'(k));
         chk(8'(pumpFactor), 8'(k));
      end
      wr(1'b0, 8'hAC);
      wr(1'b0, 8'h00);
      chk(8'(sleepActive), 8'h01);
      wr(1'b0, 8'hAD);
      wr(1'b0, 8'h00);
      chk(8'(sleepActive), 8'h00);
      $display("test operands done");
      put(1'b0, 1'b0, 8'hF3);
      chk(8'(reqRejected), 8'h01);
      chk(8'(u_lcd_bus_if.busWrite), 8'h00);
      @(negedge clk_sys);
      wr(1'b0, 8'hF8);
      put(1'b0, 1'b0, 8'hF1);
      chk(8'(reqRejected), 8'h00);
      repeat (2) @(negedge clk_sys);
      chk(8'(pumpFactor), 8'h01);
      $display("test refusal done");
      wr(1'b0, 8'hB0);
      wr(1'b0, 8'h10);
      wr(1'b0, 8'h00);
      wr(1'b1, 8'h5A);
      wr(1'b1, 8'hA5);
      chk(columnAddr, 8'h02);
      wr(1'b0, 8'h00);
      rd(1'b1, 8'h5A);
      wr(1'b0, 8'hE0);
      chk(8'(rmwActive), 8'h01);
      rd(1'b1, 8'hA5);
      chk(columnAddr, 8'h01);
      wr(1'b1, 8'h3C);
      chk(columnAddr, 8'h02);
      wr(1'b0, 8'hEE);
      chk(8'(rmwActive), 8'h00);
      wr(1'b0, 8'h01);
      rd(1'b1, 8'h3C);
      $display("test memory done");
      wr(1'b0, 8'h81);
      wr(1'b0, 8'h15);
      wr(1'b0, 8'hE3);
      chk(8'(contrastStep), 8'h15);
      wr(1'b0, 8'hA1);
      wr(1'b0, 8'h6A);
      wr(1'b0, 8'hB3);
      rd(1'b0, 8'h60);
      chk(8'(startLine), 8'h2A);
      chk(8'(pageAddr), 8'h03);
      wr(1'b0, 8'hE2);
      chk(8'(contrastStep), 8'h00);
      chk(columnAddr, 8'h00);
      chk(8'(startLine), 8'h00);
      chk(8'(pageAddr), 8'h00);
      rd(1'b0, 8'h20);
      $display("test soft reset done");
      close_out();
   end
endmodule

`default_nettype wire
